// ### design/ebpc_expansion_bus.sv
`timescale 1ns/1ps
module ebpc_expansion_bus (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic ext_bus_clock_in,
    input wire ebpc_pkg::ebpc_cfg_s cfg_in,
    input wire logic req_valid_in,
    input wire ebpc_pkg::ebpc_req_s req_in,
    output logic busy_out,
    output logic done_out,
    output logic [ebpc_pkg::DATA_W-1:0] rdata_out,
    input wire logic shared_wait_n_in,
    input wire logic [ebpc_pkg::NUM_RDY-1:0] hostport_ready_in,
    input wire logic [ebpc_pkg::DATA_W-1:0] ext_data_bus_in,
    output logic [ebpc_pkg::DATA_W-1:0] ext_data_bus_out,
    output logic ext_data_bus_oe_out,
    output logic [ebpc_pkg::ADDR_W-1:0] ext_address_bus_out,
    output logic addr_latch_en_out,
    output logic [ebpc_pkg::NUM_CS-1:0] device_select_n_out,
    output logic bus_read_ctl_n_out,
    output logic bus_write_ctl_n_out
);
    import ebpc_pkg::*;

    // Host-port mode on a low select falls back to split strobes.
    function automatic logic [1:0] eff_mode(input logic [CS_W-1:0] cs,
                                            input logic [1:0] mode);
        if (mode == MODE_HOSTPORT && cs < FIRST_HP_CS) begin
            eff_mode = MODE_SPLIT;
        end else if (mode == MODE_HOSTPORT || mode == MODE_DSTROBE) begin
            eff_mode = mode;
        end else begin
            eff_mode = MODE_SPLIT;
        end
    endfunction

    // ****************************************************************
    // System side: request capture and completion
    // ****************************************************************
    // The job word stays frozen from the request toggle until the done
    // toggle returns, so the link side may read it without a sync.
    ebpc_job_s job_ff, nxt_job;
    logic busy_ff, nxt_busy;
    logic done_ff, nxt_done;
    logic req_tgl_ff, nxt_req_tgl;
    logic [DATA_W-1:0] rdata_ff, nxt_rdata;
    logic dtg_s1_ff, dtg_s2_ff, dtg_s3_ff;
    logic nxt_dtg_s3;

    logic done_tgl_ff;
    logic [DATA_W-1:0] link_rdata_ff;

    always_comb begin
        nxt_job = job_ff;
        nxt_busy = busy_ff;
        nxt_done = 1'b0;
        nxt_req_tgl = req_tgl_ff;
        nxt_rdata = rdata_ff;
        nxt_dtg_s3 = dtg_s2_ff;
        if (busy_ff && (dtg_s2_ff != dtg_s3_ff)) begin
            nxt_busy = 1'b0;
            nxt_done = 1'b1;
            nxt_rdata = link_rdata_ff;
        end else if (!busy_ff && req_valid_in) begin
            nxt_job.write = req_in.write;
            nxt_job.cs = req_in.cs;
            nxt_job.addr = req_in.addr;
            nxt_job.wdata = req_in.wdata;
            nxt_job.mode = eff_mode(req_in.cs, cfg_in.cs_mode[req_in.cs]);
            nxt_job.mux = cfg_in.cs_mux[req_in.cs];
            nxt_job.rdy_active_low = cfg_in.rdy_active_low;
            nxt_busy = 1'b1;
            nxt_req_tgl = ~req_tgl_ff;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            job_ff <= JOB_RST;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            req_tgl_ff <= 1'b0;
            rdata_ff <= DATA_RST;
            dtg_s1_ff <= 1'b0;
            dtg_s2_ff <= 1'b0;
            dtg_s3_ff <= 1'b0;
        end else begin
            job_ff <= nxt_job;
            busy_ff <= nxt_busy;
            done_ff <= nxt_done;
            req_tgl_ff <= nxt_req_tgl;
            rdata_ff <= nxt_rdata;
            dtg_s1_ff <= done_tgl_ff;
            dtg_s2_ff <= dtg_s1_ff;
            dtg_s3_ff <= nxt_dtg_s3;
        end
    end

    assign busy_out = busy_ff;
    assign done_out = done_ff;
    assign rdata_out = rdata_ff;

    // ****************************************************************
    // Link side: pin sequencing on the bus clock
    // ****************************************************************
    ebpc_state_e state_ff, nxt_state;
    logic [1:0] scnt_ff, nxt_scnt;
    logic nxt_done_tgl;
    logic [DATA_W-1:0] nxt_link_rdata;
    logic rtg_s1_ff, rtg_s2_ff, rtg_s3_ff;
    logic nxt_rtg_s3;
    logic wait_s1_ff, wait_s2_ff;
    logic [NUM_RDY-1:0] rdy_s1_ff, rdy_s2_ff;
    logic [DATA_W-1:0] din_s1_ff, din_s2_ff;
    logic [DATA_W-1:0] dout_ff, nxt_dout;
    logic doe_ff, nxt_doe;
    logic [ADDR_W-1:0] addr_ff, nxt_addr;
    logic ale_ff, nxt_ale;
    logic [NUM_CS-1:0] cs_n_ff, nxt_cs_n;
    logic rd_n_ff, nxt_rd_n;
    logic wr_n_ff, nxt_wr_n;
    logic rdy_act;
    logic halted;

    always_comb begin
        rdy_act = rdy_s2_ff[job_ff.cs[1:0]] ^ job_ff.rdy_active_low;
        if (job_ff.mode == MODE_HOSTPORT) begin
            halted = !rdy_act;
        end else begin
            halted = !wait_s2_ff;
        end
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_scnt = scnt_ff;
        nxt_done_tgl = done_tgl_ff;
        nxt_link_rdata = link_rdata_ff;
        nxt_dout = dout_ff;
        nxt_doe = doe_ff;
        nxt_addr = addr_ff;
        nxt_ale = 1'b0;
        nxt_cs_n = cs_n_ff;
        nxt_rd_n = rd_n_ff;
        nxt_wr_n = wr_n_ff;
        nxt_rtg_s3 = rtg_s3_ff;
        unique case (state_ff)
            ST_IDLE: begin
                if (rtg_s2_ff != rtg_s3_ff) begin
                    nxt_rtg_s3 = rtg_s2_ff;
                    nxt_addr = job_ff.addr;
                    nxt_scnt = STROBE_CNT_RST;
                    if (job_ff.mux && job_ff.mode != MODE_HOSTPORT) begin
                        nxt_ale = 1'b1;
                        nxt_dout = job_ff.addr[DATA_W-1:0];
                        nxt_doe = 1'b1;
                        nxt_state = ST_ALE;
                    end else begin
                        nxt_state = ST_SETUP;
                    end
                end
            end
            ST_ALE: begin
                nxt_doe = 1'b0;
                nxt_state = ST_SETUP;
            end
            ST_SETUP: begin
                nxt_cs_n = CS_IDLE;
                nxt_cs_n[job_ff.cs] = 1'b0;
                nxt_dout = job_ff.wdata;
                nxt_doe = job_ff.write;
                if (job_ff.mode != MODE_SPLIT) begin
                    nxt_rd_n = !job_ff.write;
                end
                nxt_state = ST_STROBE;
            end
            ST_STROBE: begin
                if (job_ff.mode != MODE_SPLIT) begin
                    nxt_wr_n = 1'b0;
                end else if (job_ff.write) begin
                    nxt_wr_n = 1'b0;
                end else begin
                    nxt_rd_n = 1'b0;
                end
                // The count freezes while halted, so release resumes the
                // strobe mid-way rather than restarting it.
                if (!halted) begin
                    if (scnt_ff == STROBE_CYC) begin
                        nxt_link_rdata = din_s2_ff;
                        nxt_state = ST_HOLD;
                    end else begin
                        nxt_scnt = scnt_ff + 2'h1;
                    end
                end
            end
            ST_HOLD: begin
                nxt_cs_n = CS_IDLE;
                nxt_rd_n = 1'b1;
                nxt_wr_n = 1'b1;
                nxt_doe = 1'b0;
                nxt_done_tgl = ~done_tgl_ff;
                nxt_state = ST_IDLE;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // Pins are launched and sampled on the bus clock only.
    always_ff @(posedge ext_bus_clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_ff <= ST_IDLE;
            scnt_ff <= STROBE_CNT_RST;
            done_tgl_ff <= 1'b0;
            link_rdata_ff <= DATA_RST;
            rtg_s1_ff <= 1'b0;
            rtg_s2_ff <= 1'b0;
            rtg_s3_ff <= 1'b0;
            wait_s1_ff <= 1'b1;
            wait_s2_ff <= 1'b1;
            rdy_s1_ff <= '1;
            rdy_s2_ff <= '1;
            din_s1_ff <= DATA_RST;
            din_s2_ff <= DATA_RST;
            dout_ff <= DATA_RST;
            doe_ff <= 1'b0;
            addr_ff <= ADDR_RST;
            ale_ff <= 1'b0;
            cs_n_ff <= CS_IDLE;
            rd_n_ff <= 1'b1;
            wr_n_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            scnt_ff <= nxt_scnt;
            done_tgl_ff <= nxt_done_tgl;
            link_rdata_ff <= nxt_link_rdata;
            rtg_s1_ff <= req_tgl_ff;
            rtg_s2_ff <= rtg_s1_ff;
            rtg_s3_ff <= nxt_rtg_s3;
            wait_s1_ff <= shared_wait_n_in;
            wait_s2_ff <= wait_s1_ff;
            rdy_s1_ff <= hostport_ready_in;
            rdy_s2_ff <= rdy_s1_ff;
            din_s1_ff <= ext_data_bus_in;
            din_s2_ff <= din_s1_ff;
            dout_ff <= nxt_dout;
            doe_ff <= nxt_doe;
            addr_ff <= nxt_addr;
            ale_ff <= nxt_ale;
            cs_n_ff <= nxt_cs_n;
            rd_n_ff <= nxt_rd_n;
            wr_n_ff <= nxt_wr_n;
        end
    end

    assign ext_data_bus_out = dout_ff;
    assign ext_data_bus_oe_out = doe_ff;
    assign ext_address_bus_out = addr_ff;
    assign addr_latch_en_out = ale_ff;
    assign device_select_n_out = cs_n_ff;
    assign bus_read_ctl_n_out = rd_n_ff;
    assign bus_write_ctl_n_out = wr_n_ff;

endmodule // ebpc_expansion_bus

// ### design/ebpc_pkg.sv
package ebpc_pkg;

    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int NUM_CS = 8;
    localparam int NUM_RDY = 4;
    localparam int CS_W = 3;

    // Final strobe count; before wait stretching the strobe lasts this plus one bus clock cycles.
    localparam logic [1:0] STROBE_CYC = 2'h2;
    localparam logic [1:0] STROBE_CNT_RST = 2'h0;

    localparam logic [1:0] MODE_SPLIT = 2'h0;
    localparam logic [1:0] MODE_DSTROBE = 2'h1;
    localparam logic [1:0] MODE_HOSTPORT = 2'h2;

    localparam logic [2:0] FIRST_HP_CS = 3'h4;
    localparam logic [NUM_CS-1:0] CS_IDLE = 8'hff;
    localparam logic [ADDR_W-1:0] ADDR_RST = 24'hffffff;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

    typedef struct packed {
        logic [NUM_CS-1:0][1:0] cs_mode;
        logic [NUM_CS-1:0] cs_mux;
        logic rdy_active_low;
    } ebpc_cfg_s;

    typedef struct packed {
        logic write;
        logic [CS_W-1:0] cs;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } ebpc_req_s;

    // Request as the link side sees it, with the select's mode resolved.
    typedef struct packed {
        logic write;
        logic [CS_W-1:0] cs;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [1:0] mode;
        logic mux;
        logic rdy_active_low;
    } ebpc_job_s;

    localparam ebpc_job_s JOB_RST = '0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ALE = 3'b001,
        ST_SETUP = 3'b010,
        ST_STROBE = 3'b011,
        ST_HOLD = 3'b100
    } ebpc_state_e;

endpackage

// ### verification/ebpc_props.sv
`timescale 1ns/1ps
// ****
// Pin checks
// ****
module ebpc_props (
    input wire logic ext_bus_clock_in,
    input wire logic rst_n_in,
    input wire ebpc_pkg::ebpc_cfg_s cfg_in,
    input wire logic shared_wait_n_in,
    input wire logic [3:0] hostport_ready_in,
    input wire logic [15:0] ext_data_bus_out,
    input wire logic ext_data_bus_oe_out,
    input wire logic [23:0] ext_address_bus_out,
    input wire logic addr_latch_en_out,
    input wire logic [7:0] device_select_n_out,
    input wire logic bus_read_ctl_n_out,
    input wire logic bus_write_ctl_n_out
);
    import ebpc_pkg::*;
    logic [1:0] j;
    logic [1:0] md;
    logic [2:0] wh_ff;
    logic [11:0] rh_ff;
    logic [3:0] nrdy;
    logic hp, spl, strb;
    // Three samples of history cover the two-flop input sync plus one spare.
    always_ff @(posedge ext_bus_clock_in) begin
        wh_ff <= {wh_ff[1:0], shared_wait_n_in};
        rh_ff <= {rh_ff[7:0], hostport_ready_in};
    end
    always_comb begin
        j = 2'h0;
        md = MODE_SPLIT;
        for (int i = 0; i < 8; i++) begin
            if (!device_select_n_out[i]) begin
                md = cfg_in.cs_mode[i];
                j = 2'(i);
            end
        end
        hp = md == MODE_HOSTPORT && device_select_n_out[3:0] == 4'hf;
        spl = !hp && md != MODE_DSTROBE;
        strb = !bus_write_ctl_n_out || (spl && !bus_read_ctl_n_out);
        nrdy = {rh_ff[8 + j], rh_ff[4 + j], rh_ff[j], hostport_ready_in[j]};
        nrdy = nrdy ^ {4{!cfg_in.rdy_active_low}};
    end
    default clocking @(posedge ext_bus_clock_in);
    endclocking
    default disable iff (!rst_n_in);
    reset_idle_a: assert property ($rose(rst_n_in) |->
        &{device_select_n_out, bus_read_ctl_n_out}) else $error("not idle");
    one_select_a: assert property ($onehot0(~device_select_n_out))
        else $error("two selects low");
    ale_addr_a: assert property (addr_latch_en_out |->
        ext_data_bus_oe_out && ext_data_bus_out == ext_address_bus_out[15:0]
        ##1 !addr_latch_en_out) else $error("bad address latch cycle");
    split_excl_a: assert property (spl |->
        bus_read_ctl_n_out || bus_write_ctl_n_out) else $error("both low");
    wait_halt_a: assert property (strb && !hp && wh_ff == 3'h0
        |=> strb) else $error("strobe ran on during wait");
    wait_go_a: assert property (strb && !hp &&
        &{wh_ff, shared_wait_n_in} |-> ##[1:3] !strb) else $error("stuck");
    ready_halt_a: assert property (strb && hp && &nrdy[3:1]
        |=> strb) else $error("strobe ran on while not ready");
    ready_go_a: assert property (strb && hp && nrdy == 4'h0
        |-> ##[1:3] !strb) else $error("strobe stuck while ready");
endmodule // ebpc_props

// ### verification/ebpc_far_dev.sv
`timescale 1ns/1ps
// ****
// Far-side device model
// ****
module ebpc_far_dev (
    input wire logic clk_in,
    input wire logic [7:0] cs_n_in,
    input wire logic rd_n_in,
    input wire logic wr_n_in,
    input wire logic ale_in,
    input wire logic oe_in,
    input wire logic [15:0] dout_in,
    input wire logic [23:0] addr_in,
    input wire logic rdy_low_in,
    input wire logic [31:0] wait_cyc_in,
    input wire logic [31:0] rdy_cyc_in,
    output logic [15:0] din_out,
    output logic wait_n_out,
    output logic [3:0] rdy_out,
    output logic [31:0] len_out,
    output logic [2:0] seen_out
);
    logic [15:0] mem [logic [23:0]];
    logic [15:0] wd;
    logic [2:0] sn;
    logic sel, psel, w;
    int cw, cr, n;
    initial begin
        {din_out, wd, sn, psel, w, len_out, seen_out} = '0;
        {cw, cr, n} = '0;
        wait_n_out = 1'b1;
        rdy_out = 4'hf;
        forever begin
            @(posedge clk_in);
            #1;
            sel = cs_n_in != 8'hff;
            sn[2] = sn[2] | ale_in;
            if (sel) begin
                n++;
                sn[1:0] = sn[1:0] | {!rd_n_in, !wr_n_in};
                w = w | (oe_in && !ale_in);
                if (oe_in) begin
                    wd = dout_in;
                end
            end
            if (sel && !psel) begin
                cw = wait_cyc_in;
                cr = rdy_cyc_in;
            end else begin
                cw = cw > 0 ? cw - 1 : 0;
                cr = cr > 0 ? cr - 1 : 0;
            end
            if (psel && !sel) begin
                if (w) begin
                    mem[addr_in] = wd;
                end
                len_out = n;
                seen_out = sn;
                {n, sn, w} = '0;
            end
            psel = sel;
            wait_n_out = cw == 0;
            // Unrelated ready lines sit not-ready so a wrong pairing stalls.
            for (int i = 0; i < 4; i++) begin
                rdy_out[i] = rdy_low_in ^ (!cs_n_in[i + 4] && cr == 0);
            end
            din_out = ~din_out;
            if (sel && !oe_in) begin
                din_out = mem.exists(addr_in) ? mem[addr_in] : addr_in[15:0];
            end
        end
    end
endmodule // ebpc_far_dev

// ### verification/tb_top.sv
`timescale 1ns/1ps
// ****
// Bench top
// ****
module tb_top;
    import ebpc_pkg::*;
    logic sys_clk_in, ext_bus_clock_in, rst_n_in, req_valid_in;
    logic busy_out, done_out, ext_data_bus_oe_out, addr_latch_en_out;
    logic bus_read_ctl_n_out, bus_write_ctl_n_out, shared_wait_n_in;
    logic [15:0] rdata_out, ext_data_bus_in, ext_data_bus_out, dev_d;
    logic [23:0] ext_address_bus_out;
    logic [7:0] device_select_n_out;
    logic [3:0] hostport_ready_in;
    logic [2:0] seen;
    logic [31:0] rs, wc, rc, len;
    ebpc_cfg_s cfg_in;
    ebpc_req_s req_in;
    int err_count, checks, cyc;
    logic [15:0] mdl [logic [23:0]];
    assign ext_data_bus_in = ext_data_bus_oe_out ? ext_data_bus_out : dev_d;
    ebpc_expansion_bus u_dut (.*);
    ebpc_far_dev u_dev (.clk_in(ext_bus_clock_in),
        .cs_n_in(device_select_n_out), .rd_n_in(bus_read_ctl_n_out),
        .wr_n_in(bus_write_ctl_n_out), .ale_in(addr_latch_en_out),
        .oe_in(ext_data_bus_oe_out), .dout_in(ext_data_bus_out),
        .addr_in(ext_address_bus_out), .rdy_low_in(cfg_in.rdy_active_low),
        .wait_cyc_in(wc), .rdy_cyc_in(rc), .din_out(dev_d),
        .wait_n_out(shared_wait_n_in), .rdy_out(hostport_ready_in),
        .len_out(len), .seen_out(seen));
    initial begin
        sys_clk_in = 1'b0;
        forever #20 sys_clk_in = ~sys_clk_in;
    end
    initial begin
        ext_bus_clock_in = 1'b0;
        #7;
        forever #40 ext_bus_clock_in = ~ext_bus_clock_in;
    end
    function automatic logic [31:0] xs();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction
    task automatic cmp(input string nm, input logic [31:0] e, s);
        checks++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, s);
        end
    endtask
    task automatic acc(input logic wr, input logic [2:0] c,
        input logic [23:0] a, input logic [15:0] d, input logic [31:0] ws, rr);
        logic hp, spl;
        logic [2:0] es;
        logic [15:0] ex;
        logic [31:0] el;
        int n;
        hp = cfg_in.cs_mode[c] == MODE_HOSTPORT && c >= FIRST_HP_CS;
        spl = !hp && cfg_in.cs_mode[c] != MODE_DSTROBE;
        es = {cfg_in.cs_mux[c] && !hp, spl ? !wr : wr, spl ? wr : 1'b1};
        ex = mdl.exists(a) ? mdl[a] : a[15:0];
        wc = ws;
        rc = rr;
        req_in = '{wr, c, a, d};
        req_valid_in = 1'b1;
        @(posedge sys_clk_in);
        #1;
        req_valid_in = 1'b0;
        cmp("busy", 1, busy_out);
        n = 0;
        while (done_out !== 1'b1 && n < 500) begin
            @(posedge sys_clk_in);
            #1;
            n++;
        end
        cmp("done", 1, done_out);
        cmp("idle", 0, busy_out);
        cmp("address", a, ext_address_bus_out);
        if (wr) begin
            mdl[a] = d;
        end else begin
            cmp("rdata", ex, rdata_out);
        end
        // Selects stay low for the counted strobe plus hold. Host-port
        // ready is only driven once selected, so its sync adds two cycles.
        el = STROBE_CYC + 2 + (hp ? 2 + rr : ws);
        cmp("length", el, len);
        cmp("strobes", es, seen);
    endtask
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    always @(posedge sys_clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            end_of_test();
        end
    end
    initial begin
        logic [23:0] a;
        {rst_n_in, req_valid_in, req_in, cfg_in, wc, rc} = '0;
        {err_count, checks, cyc} = '0;
        rs = 32'h73146147;
        repeat (5) @(posedge sys_clk_in);
        #1;
        rst_n_in = 1'b1;
        // Pass four repeats host-port mode with the other ready polarity.
        for (int m = 0; m < 5; m++) begin
            cfg_in = {{8{2'(m == 4 ? 2 : m)}}, 8'(xs()), m == 4};
            for (int c = 0; c < 8; c++) begin
                a = 24'(xs());
                acc(1'b1, 3'(c), a, 16'(xs()), 0, 0);
                acc(1'b0, 3'(c), a, 16'h0, xs() % 5, xs() % 5);
                acc(1'b0, 3'(c), 24'(xs()), 16'h0, xs() % 5, 0);
            end
            $display("Mode pass %0d done", m);
        end
        end_of_test();
    end
endmodule // tb_top
bind ebpc_expansion_bus ebpc_props u_props (.*);
